// File: asl_defines.svh
/*
  Constants of the audio light path: clock rate, timing, offsets, fields.
  Assumes a 20 MHz system clock.
*/
`ifndef ASL_DEFINES_SVH
`define ASL_DEFINES_SVH
`define ASL_CLK_HZ 20000000
`define ASL_SAMPLE_HZ 31250
`define ASL_SAMPLE_CYC (`ASL_CLK_HZ / `ASL_SAMPLE_HZ)
// Refresh rates in tenths of a hertz
`define ASL_REF0_DHZ 300
`define ASL_REF1_DHZ 150
`define ASL_REF2_DHZ 76
`define ASL_REF3_DHZ 38
`define ASL_REF0_CYC (`ASL_CLK_HZ / `ASL_REF0_DHZ * 10)
`define ASL_REF1_CYC (`ASL_CLK_HZ / `ASL_REF1_DHZ * 10)
`define ASL_REF2_CYC (`ASL_CLK_HZ / `ASL_REF2_DHZ * 10)
`define ASL_REF3_CYC (`ASL_CLK_HZ / `ASL_REF3_DHZ * 10)
`define ASL_OFF_LEVEL 8'h0c
`define ASL_OFF_CTRL 8'h0d
`define ASL_OFF_THR 8'h0e
`define ASL_OFF_PEAK 8'h20
`define ASL_OFF_GAIN 8'h21
`define ASL_CORNER_BIT 4
`define ASL_AGC_BIT 3
`define ASL_SYNC_BIT 2
`define ASL_RST_CTRL 8'h00
`define ASL_RST_THR 8'h00
`define ASL_RST_LEVEL 8'h00
`define ASL_ADC_MID 11'h200
`define ASL_HP_K_LO 6
`define ASL_HP_K_HI 3
`define ASL_AGC_HI 8'hf0
`define ASL_AGC_LO 8'h40
`endif

// File: asl_pkg.sv
/*
  Types of the audio light path.
  Assumes asl_defines.svh beside it.
*/
package asl_pkg;
  typedef logic signed [11:0] asl_sample_t;
  typedef logic [7:0] asl_byte_t;
  typedef enum logic [1:0] {
    ASL_OFF = 2'b00,
    ASL_ARM = 2'b01,
    ASL_RUN = 2'b11
  } asl_state_t;
endpackage : asl_pkg

// File: asl_hpf.sv
/*
  First-order DC remover on the mixed audio samples.
  Assumes a one-cycle sample enable and a synchronous clear.
*/
`timescale 1ns/1ns
`include "asl_defines.svh"
module asl_hpf (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic sample_en,
  input wire logic corner_hi,
  // Data
  input wire asl_pkg::asl_sample_t din,
  output asl_pkg::asl_sample_t dout
);
  import asl_pkg::*;
  logic signed [20:0] acc;
  logic signed [20:0] err;
  logic signed [20:0] next_step;
  assign err = {din[11], din, 8'h00} - acc;
  assign next_step = corner_hi ? (err >>> `ASL_HP_K_HI) : (err >>> `ASL_HP_K_LO);
  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      acc <= '0;
      dout <= '0;
    end else if (sample_en) begin
      acc <= acc + next_step;
      dout <= din - acc[19:8];
    end
  end
endmodule : asl_hpf

// File: asl_gain.sv
/*
  Manual or automatic attenuation of the sample magnitude.
  Assumes the peak input and the refresh tick come from the same clock.
*/
`timescale 1ns/1ns
`include "asl_defines.svh"
module asl_gain (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic refresh_tick,
  input wire logic auto_on,
  input wire logic [2:0] gain_sel,
  input wire asl_pkg::asl_byte_t peak,
  // Data
  input wire logic [10:0] mag,
  output asl_pkg::asl_byte_t dout,
  output logic [2:0] gain_code
);
  import asl_pkg::*;
  logic [2:0] agc_code;
  logic [10:0] scaled;
  // Shifts approximate the 6 dB steps; last step is 48 dB, not 42
  function automatic logic [3:0] shift_of(input logic [2:0] code);
    case (code)
      3'd6: shift_of = 4'd6;
      3'd7: shift_of = 4'd8;
      default: shift_of = {1'b0, code};
    endcase
  endfunction : shift_of
  assign gain_code = auto_on ? agc_code : gain_sel;
  assign scaled = mag >> shift_of(gain_code);
  assign dout = (scaled > 11'h0ff) ? 8'hff : scaled[7:0];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      agc_code <= 3'd0;
    end else if (refresh_tick && auto_on) begin
      if (peak >= `ASL_AGC_HI && agc_code != 3'd7) begin
        agc_code <= agc_code + 3'd1;
      end else if (peak < `ASL_AGC_LO && agc_code != 3'd0) begin
        agc_code <= agc_code - 3'd1;
      end
    end
  end
endmodule : asl_gain

// File: asl_top.sv
/*
  Audio-synchronised fun-light level control with its register port.
  Assumes an external converter presenting two 10-bit offset-binary
  samples that stay stable for many clocks; they cross in by two flops.
*/
`timescale 1ns/1ns
`include "asl_defines.svh"

module asl_top #(
  parameter int unsigned REF0_CYC = `ASL_REF0_CYC,
  parameter int unsigned REF1_CYC = `ASL_REF1_CYC,
  parameter int unsigned REF2_CYC = `ASL_REF2_CYC,
  parameter int unsigned REF3_CYC = `ASL_REF3_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire asl_pkg::asl_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output asl_pkg::asl_byte_t rd_data,
  // Converter samples
  input wire logic [9:0] adc_left,
  input wire logic [9:0] adc_right,
  // Fun light
  output asl_pkg::asl_byte_t fun_light_level,
  output logic fun_light_output
);
  import asl_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  asl_byte_t audio_sync_control;
  asl_byte_t audio_input_threshold;
  asl_byte_t host_level;
  asl_byte_t audio_level;
  asl_byte_t peak;
  asl_byte_t scaled;
  asl_state_t state;
  asl_state_t next_state;
  asl_sample_t mixed;
  asl_sample_t hp_out;
  logic [9:0] left_meta;
  logic [9:0] left_sync;
  logic [9:0] right_meta;
  logic [9:0] right_sync;
  logic [10:0] ch_sum;
  logic [10:0] mag;
  logic [10:0] gated;
  logic [9:0] sample_cnt;
  logic [22:0] ref_cnt;
  logic [22:0] ref_limit;
  logic [2:0] gain_code;
  logic sample_en;
  logic sample_d;
  logic refresh_tick;
  logic sync_on;
  logic filt_clear;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Multi-bit crossing is safe only because samples stay still for long
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      left_meta <= '0;
      left_sync <= '0;
      right_meta <= '0;
      right_sync <= '0;
    end else begin
      left_meta <= adc_left;
      left_sync <= left_meta;
      right_meta <= adc_right;
      right_sync <= right_meta;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      audio_sync_control <= `ASL_RST_CTRL;
    end else if (wr_en && addr == `ASL_OFF_CTRL) begin
      audio_sync_control <= wr_data;
    end
  end

  // Upper threshold bits are kept for readback only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      audio_input_threshold <= `ASL_RST_THR;
    end else if (wr_en && addr == `ASL_OFF_THR) begin
      audio_input_threshold <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_level <= `ASL_RST_LEVEL;
    end else if (wr_en && addr == `ASL_OFF_LEVEL) begin
      host_level <= wr_data;
    end
  end

  assign sync_on = audio_sync_control[`ASL_SYNC_BIT];

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (!rd_en) begin
      rd_data <= 8'h00;
    end else if (addr == `ASL_OFF_CTRL) begin
      rd_data <= audio_sync_control;
    end else if (addr == `ASL_OFF_THR) begin
      rd_data <= audio_input_threshold;
    end else if (addr == `ASL_OFF_LEVEL) begin
      rd_data <= host_level;
    end else if (addr == `ASL_OFF_PEAK) begin
      rd_data <= audio_level;
    end else if (addr == `ASL_OFF_GAIN) begin
      rd_data <= {5'b0_0000, gain_code};
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ----------------------------------------
  // Sample rate divider
  // One-cycle enable at the audio sample rate
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sample_cnt <= '0;
      sample_en <= 1'b0;
    end else if (sample_cnt == 10'(`ASL_SAMPLE_CYC - 1)) begin
      sample_cnt <= '0;
      sample_en <= 1'b1;
    end else begin
      sample_cnt <= sample_cnt + 10'd1;
      sample_en <= 1'b0;
    end
  end

  // Gain output settles one cycle after the filter updates
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sample_d <= 1'b0;
    end else begin
      sample_d <= sample_en;
    end
  end

  // ----------------------------------------
  // Sync state machine
  // ARM waits for a sample so the first interval starts clean
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ASL_OFF: begin
        if (sync_on) begin
          next_state = ASL_ARM;
        end
      end
      ASL_ARM: begin
        if (!sync_on) begin
          next_state = ASL_OFF;
        end else if (sample_en) begin
          next_state = ASL_RUN;
        end
      end
      ASL_RUN: begin
        if (!sync_on) begin
          next_state = ASL_OFF;
        end
      end
      default: begin
        next_state = ASL_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ASL_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Filter restarts clean each time sync is switched on
  assign filt_clear = (state != ASL_RUN) && (state != ASL_ARM);

  // ----------------------------------------
  // Mixer and filter
  // ----------------------------------------
  // stereo mixed to one wave
  assign ch_sum = {1'b0, left_sync} + {1'b0, right_sync};
  // Sum less twice mid-scale, halved: one channel's range, signed
  assign mixed = 12'(({2'b00, ch_sum} - {1'b0, `ASL_ADC_MID, 1'b0}) >> 1);

  asl_hpf u_hpf (
    .clock(clock),
    .rst_n(rst_n),
    .clear(filt_clear),
    .sample_en(sample_en),
    .corner_hi(audio_sync_control[`ASL_CORNER_BIT]),
    .din(mixed),
    .dout(hp_out)
  );

  // ----------------------------------------
  // Threshold gate and gain
  // ----------------------------------------
  // magnitude feeds peak detection
  assign mag = hp_out[11] ? 11'(-hp_out) : hp_out[10:0];

  // Threshold counts are filter output units, not millivolts
  // zero code disables gate
  always_comb begin
    gated = mag;
    if (audio_input_threshold[3:0] != 4'h0 && mag < {7'h00, audio_input_threshold[3:0]}) begin
      gated = 11'h000;
    end
  end

  asl_gain u_gain (
    .clock(clock),
    .rst_n(rst_n),
    .refresh_tick(refresh_tick),
    .auto_on(audio_sync_control[`ASL_AGC_BIT]),
    .gain_sel(audio_sync_control[2:0]),
    .peak(peak),
    .mag(gated),
    .dout(scaled),
    .gain_code(gain_code)
  );

  // ----------------------------------------
  // Refresh timer
  // ----------------------------------------
  // refresh rate select
  always_comb begin
    case (audio_sync_control[1:0])
      2'b00: ref_limit = 23'(REF0_CYC - 1);
      2'b01: ref_limit = 23'(REF1_CYC - 1);
      2'b10: ref_limit = 23'(REF2_CYC - 1);
      default: ref_limit = 23'(REF3_CYC - 1);
    endcase
  end

  // Changing the rate mid-period may stretch one period to the new limit
  always_ff @(posedge clock) begin
    if (!rst_n || state != ASL_RUN) begin
      ref_cnt <= '0;
      refresh_tick <= 1'b0;
    end else if (ref_cnt >= ref_limit) begin
      ref_cnt <= '0;
      refresh_tick <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + 23'd1;
      refresh_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Peak detector
  // ----------------------------------------
  // restart after each latch
  always_ff @(posedge clock) begin
    if (!rst_n || state != ASL_RUN) begin
      peak <= 8'h00;
    end else if (refresh_tick) begin
      // A sample on the tick edge opens the next interval
      peak <= sample_d ? scaled : 8'h00;
    end else if (sample_d && scaled > peak) begin
      peak <= scaled;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || state == ASL_OFF) begin
      audio_level <= 8'h00;
    end else if (refresh_tick) begin
      audio_level <= peak;
    end
  end

  // ----------------------------------------
  // Light outputs
  // Both pins come from flops so they never glitch
  // ----------------------------------------
  // audio path owns level while sync is on, host level otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fun_light_level <= 8'h00;
    end else if (sync_on) begin
      fun_light_level <= audio_level;
    end else begin
      fun_light_level <= host_level;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fun_light_output <= 1'b0;
    end else begin
      fun_light_output <= sync_on || (host_level != 8'h00);
    end
  end

endmodule : asl_top

// File: asl_top_chk.sv
/* Checker of the audio light path, bound to asl_top.
   Assumes the register port is the only way to change the controls. */
`timescale 1ns/1ns
module asl_top_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire asl_pkg::asl_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire asl_pkg::asl_byte_t rd_data,
  // Fun light
  input wire asl_pkg::asl_byte_t fun_light_level,
  input wire logic fun_light_output
);
  import asl_pkg::*;
  asl_byte_t ctl;
  asl_byte_t thr;
  asl_byte_t lvl;
  logic [2:0] age;
  // ------
  // Shadows
  // ------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl <= 8'h00;
      thr <= 8'h00;
      lvl <= 8'h00;
    end else if (wr_en) begin
      if (addr == 8'h0d) ctl <= wr_data;
      if (addr == 8'h0e) thr <= wr_data;
      if (addr == 8'h0c) lvl <= wr_data;
    end
  end
  // Saturating age: gain code may lag a write
  always_ff @(posedge clock) begin
    if (!rst_n || (wr_en && addr == 8'h0d)) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ------
  // Assertions
  // ------
  // driver enable
  a_drv_enable: assert property (fun_light_output == $past(ctl[2] || lvl != 8'h00))
    else $error("driver enable wrong");
  a_host_level: assert property (!$past(ctl[2]) |-> fun_light_level == $past(lvl))
    else $error("host level not shown");
  a_level_hold: assert property (ctl[2] && $past(ctl[2]) && $changed(fun_light_level)
    |=> (!ctl[2] || $stable(fun_light_level))[*8]) else $error("level moved early");
  a_ctrl_read: assert property ($past(rd_en && addr == 8'h0d) |-> rd_data == $past(ctl))
    else $error("control readback wrong");
  a_thr_read: assert property ($past(rd_en && addr == 8'h0e) |-> rd_data == $past(thr))
    else $error("threshold readback wrong");
  a_gain_manual: assert property ($past(rd_en && addr == 8'h21 && !ctl[3] && age == 3'h7)
    |-> rd_data == {5'h00, $past(ctl[2:0])}) else $error("manual gain wrong");
  a_audio_level: assert property ($past(rd_en && addr == 8'h20 && ctl[2])
    |-> rd_data == fun_light_level) else $error("light not audio level");
  a_level_read: assert property ($past(rd_en && addr == 8'h0c) |-> rd_data == $past(lvl))
    else $error("level readback wrong");
endmodule : asl_top_chk
bind asl_top asl_top_chk asl_top_chk_i (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .fun_light_level(fun_light_level), .fun_light_output(fun_light_output));

// File: asl_src.sv
/* Stereo source model: square wave about converter mid-scale.
   Assumes the bench changes the amplitude between tests. */
`timescale 1ns/1ns
module asl_src #(
  parameter int unsigned HALF_CYC = 1280
) (
  // Clock
  input wire logic clock,
  // Amplitude in counts
  input wire logic [8:0] amp,
  // Converter samples
  output logic [9:0] adc_left = 10'h200,
  output logic [9:0] adc_right = 10'h200
);
  int unsigned cnt = 0;
  logic high = 1'b0;
  always @(posedge clock) begin
    if (cnt == HALF_CYC - 1) begin
      cnt <= 0;
      high <= !high;
    end else begin
      cnt <= cnt + 1;
    end
  end
  always @(posedge clock) begin
    adc_left <= high ? 10'h200 + {1'b0, amp} : 10'h200 - {1'b0, amp};
    adc_right <= high ? 10'h200 + {1'b0, amp} : 10'h200 - {1'b0, amp};
  end
endmodule : asl_src

// File: tb_asl_top.sv
/* Bench of the audio light path: registers, then audio tests.
   Assumes the source model and the checker are compiled before it. */
`timescale 1ns/1ns
module tb_asl_top;
  import asl_pkg::*;
  localparam int unsigned REF0 = 2000;
  localparam int unsigned REF3 = 16000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  asl_byte_t wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  asl_byte_t rd_data, fun_light_level, lvl_a, d;
  logic fun_light_output;
  logic [9:0] adc_left, adc_right;
  logic [8:0] amp = 9'h000;
  logic [7:0] regs [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h20, 8'h21};
  int err_count = 0;
  int checked = 0;
  asl_top #(.REF0_CYC(REF0), .REF1_CYC(4000), .REF2_CYC(8000), .REF3_CYC(REF3)) asl_top_i (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .adc_left(adc_left), .adc_right(adc_right),
    .fun_light_level(fun_light_level), .fun_light_output(fun_light_output));
  asl_src asl_src_i (.clock(clock), .amp(amp), .adc_left(adc_left), .adc_right(adc_right));
  initial forever #25 clock = ~clock;
  // ------
  // Tasks
  // ------
  task automatic wr(input logic [7:0] a, input asl_byte_t v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic chk(input string nm, input asl_byte_t got, input asl_byte_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input asl_byte_t exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data;
    chk("rd_data", d, exp);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // ------
  // Tests
  // ------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    foreach (regs[i]) rchk(regs[i], 8'h00);
    chk("light_on", {7'h00, fun_light_output}, 8'h00);
    wr(8'h0e, 8'ha5);
    rchk(8'h0e, 8'ha5);
    wr(8'h0d, 8'h13);
    rchk(8'h0d, 8'h13);
    idle(8);
    rchk(8'h21, 8'h03);
    wr(8'h33, 8'hff);
    rchk(8'h33, 8'h00);
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'h00);
    wr(8'h0e, 8'h00);
    wr(8'h0c, 8'h5a);
    idle(2);
    chk("level", fun_light_level, 8'h5a);
    chk("light_on", {7'h00, fun_light_output}, 8'h01);
    wr(8'h0c, 8'h00);
    idle(2);
    chk("light_on", {7'h00, fun_light_output}, 8'h00);
    $display("test registers done");
    wr(8'h0c, 8'h5a);
    amp <= 9'h190;
    // gain code 4 (sync bit is also gain bit 2), 24 dB attenuation, for a loud source
    wr(8'h0d, 8'h04);
    idle(4 * REF0);
    lvl_a = fun_light_level;
    chk("level_on", {7'h00, lvl_a != 8'h00}, 8'h01);
    chk("not_host", {7'h00, lvl_a != 8'h5a}, 8'h01);
    rchk(8'h20, 8'h19);
    rchk(8'h0c, 8'h5a);
    wr(8'h0d, 8'h00);
    idle(2);
    chk("level", fun_light_level, 8'h5a);
    wr(8'h0c, 8'h00);
    wr(8'h0d, 8'h07);
    idle(REF3 / 4);
    chk("level_wait", fun_light_level, 8'h00);
    idle(REF3);
    chk("level_on", {7'h00, fun_light_level != 8'h00}, 8'h01);
    chk("level_low", {7'h00, fun_light_level < lvl_a}, 8'h01);
    wr(8'h0d, 8'h0d);
    idle(6 * REF0);
    rchk(8'h21, 8'h01);
    chk("level_agc", {7'h00, fun_light_level >= 8'h40 && fun_light_level < 8'hf0}, 8'h01);
    $display("test loud done");
    wr(8'h0d, 8'h00);
    amp <= 9'h006;
    wr(8'h0d, 8'h0c);
    idle(8 * REF0);
    chk("level_on", {7'h00, fun_light_level != 8'h00}, 8'h01);
    rchk(8'h21, 8'h00);
    wr(8'h0d, 8'h00);
    wr(8'h0e, 8'h0f);
    wr(8'h0d, 8'h0c);
    idle(8 * REF0);
    chk("level_quiet", fun_light_level, 8'h00);
    $display("test quiet done");
    summarize();
  end
endmodule : tb_asl_top
